/* File: pbseq_pkg.sv */
// Purpose: Constants and carrier types for the push-button power sequencer
// Assumes: SYS_CLK at 100 MHz; all analog comparators arrive as raw pins
// Notes:   Times are given in microseconds and converted to cycles here
// How it works
// - Power enable only after button held with supply good for whole debounce
// - Debounced power button press in normal operation asserts interrupt low
// - Supply undervoltage in normal operation also asserts interrupt low
// - Both buttons held through long-push delay pulse reset or drop power
// - Host raising hold-confirm during startup keeps power enable on
// - Host lowering hold-confirm in normal operation drops power enable
// - Internal pull-down on hold-confirm active only during startup
// - Second button watched for falling edges only after power-up completes
// - Long-push delay ends when delay capacitor comparator reports threshold
// - Without delay capacitor long push follows minimum interrupt time directly
// - Reference enable on one cycle as startup begins, off through reset pulse, on after it ends, off in standby
// - Supply comparator watched during startup and normal operation
// - Both buttons are active low, idle high
// - Supply dip during debounce clears counter, restarts on recovery
// - Held variant drops power if button released while hold-confirm low
// - Hold-confirm low at blanking window end drops power immediately
// - Valid startup drives reset low for the reset pulse time
package pbseq_pkg;

  localparam int CLK_MHZ            = 100;
  localparam int DEBOUNCE_US        = 30000;
  localparam int INT_MIN_US         = 30000;
  localparam int RESET_PULSE_US     = 200000;
  localparam int ON_BLANK_US        = 3000000;
  localparam int DEBOUNCE_CYC       = DEBOUNCE_US * CLK_MHZ;
  localparam int INT_MIN_CYC        = INT_MIN_US * CLK_MHZ;
  localparam int RESET_PULSE_CYC    = RESET_PULSE_US * CLK_MHZ;
  localparam int ON_BLANK_CYC       = ON_BLANK_US * CLK_MHZ;
  localparam int CNT_W              = 32;
  localparam logic [2:0] SYNC_RESET = 3'h7;

  typedef enum logic {
    ACT_RESET_PULSE,
    ACT_POWER_OFF
  } long_push_action_t;

  typedef enum logic {
    START_BUTTON_HELD,
    START_BLANKING
  } startup_variant_t;

  typedef struct packed {
    logic power_button_n;
    logic second_button_n;
    logic hold_confirm;
    logic supply_low_flag;
    logic delay_cap_threshold;
  } pins_in_t;

endpackage : pbseq_pkg

/* File: pbseq_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for one pin
// Assumes: Input is asynchronous to SYS_CLK
// Notes:   Output follows only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pbseq_sync
(
  input  wire logic SYS_CLK,
  input  wire logic RST_N,
  input  wire logic RESET_VALUE,
  input  wire logic PIN,
  output var  logic LEVEL
);
  logic [2:0] stage_reg;
  logic       level_reg;
  logic       agree;

  assign agree = (stage_reg[1] == stage_reg[2]);
  assign LEVEL = level_reg;

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      stage_reg <= 3'h7;
      level_reg <= 1'b1;
    end
    else
    begin
      stage_reg <= {stage_reg[1:0], PIN};
      if (agree)
        level_reg <= stage_reg[2];
    end
  end
endmodule : pbseq_sync
`default_nettype wire

/* File: pbseq_top.sv */
// Purpose: Push-button power sequencer core
// Assumes: Comparator flags and buttons are raw asynchronous pins
// Notes:   Open-drain outputs are modelled as active-low levels
`timescale 1ns/1ps
`default_nettype none
module pushbutton_power_sequencer
#(
  parameter pbseq_pkg::long_push_action_t LONG_ACTION = pbseq_pkg::ACT_RESET_PULSE,
  parameter pbseq_pkg::startup_variant_t  START_MODE  = pbseq_pkg::START_BUTTON_HELD,
  parameter bit                           DELAY_CAP_FITTED = 1'b1,
  parameter int                           DEBOUNCE_CYC     = pbseq_pkg::DEBOUNCE_CYC,
  parameter int                           INT_MIN_CYC      = pbseq_pkg::INT_MIN_CYC,
  parameter int                           RESET_PULSE_CYC  = pbseq_pkg::RESET_PULSE_CYC,
  parameter int                           ON_BLANK_CYC     = pbseq_pkg::ON_BLANK_CYC
)
(
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire pbseq_pkg::pins_in_t PINS,
  output var  logic              POWER_ENABLE,
  output var  logic              INT_N,
  output var  logic              RESET_N,
  output var  logic              BUTTON_STATE_OUT_N,
  output var  logic              SUPPLY_LOW_N,
  output var  logic              REF_ENABLE,
  output var  logic              HOLD_PULLDOWN_EN
);
  import pbseq_pkg::*;

  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_DEBOUNCE,
    ST_STARTUP,
    ST_NORMAL,
    ST_LONG_WAIT
  } state_t;

  state_t            state_reg;
  state_t            state_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  rst_cnt_reg;
  logic [CNT_W-1:0]  int_cnt_reg;
  logic              pb_n;
  logic              sr_n;
  logic              hold;
  logic              low;
  logic              cap_hit;
  logic              sr_prev_reg;
  logic              sr_armed_reg;
  logic              en_reg;
  logic              int_reg;
  logic              rst_reg;
  logic              bout_reg;
  logic              ref_reg;
  logic              pd_reg;
  logic              low_reg;

  pbseq_sync u_pb  (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .RESET_VALUE(1'b1),
                    .PIN(PINS.power_button_n), .LEVEL(pb_n));
  pbseq_sync u_sr  (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .RESET_VALUE(1'b1),
                    .PIN(PINS.second_button_n), .LEVEL(sr_n));
  pbseq_sync u_hc  (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .RESET_VALUE(1'b1),
                    .PIN(PINS.hold_confirm), .LEVEL(hold));
  pbseq_sync u_low (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .RESET_VALUE(1'b1),
                    .PIN(PINS.supply_low_flag), .LEVEL(low));
  pbseq_sync u_cap (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .RESET_VALUE(1'b1),
                    .PIN(PINS.delay_cap_threshold), .LEVEL(cap_hit));

  // Synchroniser resets high, so buttons read idle but supply and delay flags read asserted; supply_low_flag pin is high=low supply

  wire pb_pressed   = !pb_n;
  wire both_pressed = !pb_n && !sr_n && sr_armed_reg;
  wire cnt_done_db  = (cnt_reg >= CNT_W'(DEBOUNCE_CYC - 1));
  wire cnt_done_bl  = (cnt_reg >= CNT_W'(ON_BLANK_CYC - 1));
  wire cnt_done_im  = (cnt_reg >= CNT_W'(DEBOUNCE_CYC + INT_MIN_CYC - 1));
  wire reset_busy   = (rst_cnt_reg != '0);
  // no capacitor means long push right after the minimum interrupt time
  wire delay_over   = DELAY_CAP_FITTED ? cap_hit : 1'b1;
  wire sr_fall      = sr_prev_reg && !sr_n;
  wire pb_int       = pb_pressed && (cnt_reg >= CNT_W'(DEBOUNCE_CYC - 1)) && !low;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_STANDBY:
        if (pb_pressed && !low)
          state_next = ST_DEBOUNCE;
      ST_DEBOUNCE:
        if (!pb_pressed)
          state_next = ST_STANDBY;
        else if (cnt_done_db && !low)
          state_next = ST_STARTUP;
      ST_STARTUP:
        if (START_MODE == START_BUTTON_HELD && !pb_pressed && !hold)
          state_next = ST_STANDBY;
        else if (cnt_done_bl)
          state_next = hold ? ST_NORMAL : ST_STANDBY;
      ST_NORMAL:
        if (!hold)
          state_next = ST_STANDBY;
        else if (both_pressed && cnt_done_im)
          state_next = ST_LONG_WAIT;
      ST_LONG_WAIT:
        if (!hold)
          state_next = ST_STANDBY;
        else if (!both_pressed)
          state_next = ST_NORMAL;
        else if (delay_over)
          state_next = (LONG_ACTION == ACT_POWER_OFF) ? ST_STANDBY : ST_STARTUP;
      default:
        state_next = ST_STANDBY;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      state_reg <= ST_STANDBY;
    else
      state_reg <= state_next;
  end

  // Shared timer: debounce (with supply check), blanking, and press length in normal
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      cnt_reg <= '0;
    else if (state_next != state_reg)
      cnt_reg <= '0;
    else if (state_reg == ST_DEBOUNCE && low)
      cnt_reg <= '0;
    else if (state_reg == ST_NORMAL && !pb_pressed)
      cnt_reg <= '0;
    else if (cnt_reg != '1)
      cnt_reg <= cnt_reg + 1'b1;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rst_cnt_reg <= '0;
    else if (state_next == ST_STARTUP && state_reg != ST_STARTUP)
      rst_cnt_reg <= CNT_W'(RESET_PULSE_CYC);
    else if (reset_busy)
      rst_cnt_reg <= rst_cnt_reg - 1'b1;
  end

  // Interrupt stays low at least the minimum time once raised
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      int_cnt_reg <= '0;
    else if (state_reg == ST_NORMAL && (pb_int || low))
      int_cnt_reg <= CNT_W'(INT_MIN_CYC);
    else if (int_cnt_reg != '0)
      int_cnt_reg <= int_cnt_reg - 1'b1;
  end

  // Second button edges count only after power-up
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sr_prev_reg  <= 1'b1;
      sr_armed_reg <= 1'b0;
    end
    else
    begin
      sr_prev_reg <= sr_n;
      if (state_reg != ST_NORMAL && state_reg != ST_LONG_WAIT)
        sr_armed_reg <= 1'b0;
      else if (sr_fall)
        sr_armed_reg <= 1'b1;
      else if (sr_n)
        sr_armed_reg <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      en_reg   <= 1'b0;
      int_reg  <= 1'b1;
      rst_reg  <= 1'b1;
      bout_reg <= 1'b1;
      ref_reg  <= 1'b0;
      pd_reg   <= 1'b0;
      low_reg  <= 1'b1;
    end
    else
    begin
      en_reg   <= (state_next == ST_STARTUP || state_next == ST_NORMAL ||
                   state_next == ST_LONG_WAIT);
      int_reg  <= !(state_reg == ST_NORMAL && (pb_int || low || int_cnt_reg != '0));
      rst_reg  <= !reset_busy;
      bout_reg <= !(pb_pressed && !low);
      // Reference is on one cycle as startup begins, off through the reset pulse, then on; standby kills it
      ref_reg  <= (state_next != ST_STANDBY) && (state_next != ST_DEBOUNCE) &&
                  !reset_busy;
      pd_reg   <= (state_next == ST_STARTUP);
      low_reg  <= !(low && state_reg != ST_STANDBY);
    end
  end

  assign POWER_ENABLE       = en_reg;
  assign INT_N              = int_reg;
  assign RESET_N            = rst_reg;
  assign BUTTON_STATE_OUT_N = bout_reg;
  assign SUPPLY_LOW_N       = low_reg;
  assign REF_ENABLE         = ref_reg;
  assign HOLD_PULLDOWN_EN   = pd_reg;
endmodule : pushbutton_power_sequencer
`default_nettype wire

/* File: pbseq_checker.sv */
// Purpose: Concurrent checks on the power sequencer pins
// Assumes: Pins reach the core a few cycles late through synchronisers
// Notes:   Bound to every sequencer instance
`timescale 1ns/1ps
`default_nettype none
module pbseq_checker
#(
  parameter int RESET_PULSE_CYC = 15,
  parameter int INT_MIN_CYC     = 10
)
(
  input wire logic                SYS_CLK,
  input wire logic                RST_N,
  input wire pbseq_pkg::pins_in_t PINS,
  input wire logic                POWER_ENABLE,
  input wire logic                INT_N,
  input wire logic                RESET_N,
  input wire logic                REF_ENABLE,
  input wire logic                HOLD_PULLDOWN_EN
);
  import pbseq_pkg::*;
  int   rlo_cnt;
  int   ilo_cnt;
  logic normal;
  assign normal = POWER_ENABLE & ~HOLD_PULLDOWN_EN;
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rlo_cnt <= 0;
      ilo_cnt <= 0;
    end
    else
    begin
      rlo_cnt <= RESET_N ? 0 : rlo_cnt + 1;
      ilo_cnt <= INT_N ? 0 : ilo_cnt + 1;
    end
  end
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  // Sampled ten cycles back to clear the synchroniser latency
  a_power_needs_press: assert property ($rose(POWER_ENABLE) |->
    !$past(PINS.power_button_n, 10) && !$past(PINS.supply_low_flag, 10))
    else $error("power on without held press");
  a_reset_with_power: assert property ($fell(RESET_N) |-> POWER_ENABLE && HOLD_PULLDOWN_EN)
    else $error("reset pulse outside startup");
  a_reset_pulse_width: assert property ($rose(RESET_N) |-> rlo_cnt == RESET_PULSE_CYC)
    else $error("reset pulse width wrong");
  a_ref_after_reset: assert property ($rose(REF_ENABLE) |-> RESET_N && POWER_ENABLE)
    else $error("reference on too early");
  a_int_quiet_startup: assert property (HOLD_PULLDOWN_EN && $past(HOLD_PULLDOWN_EN) |-> INT_N)
    else $error("interrupt during startup");
  a_int_min_width: assert property ($rose(INT_N) && POWER_ENABLE |-> ilo_cnt >= INT_MIN_CYC)
    else $error("interrupt too short");
  a_undervolt_int: assert property ((normal && PINS.supply_low_flag) [*8] |-> !INT_N)
    else $error("undervoltage without interrupt");
  a_hold_low_off: assert property ((normal && !PINS.hold_confirm) [*8] |-> !POWER_ENABLE)
    else $error("hold low kept power on");
  // Power-on raises enable one cycle before reset falls, so look two cycles back
  a_long_push_both: assert property ($fell(RESET_N) && $past(POWER_ENABLE, 2) |->
    !$past(PINS.power_button_n, 8) && !$past(PINS.second_button_n, 8))
    else $error("long push without both buttons");
  c_long_push: cover property ($fell(RESET_N) && $past(POWER_ENABLE, 2));
  c_interrupt: cover property ($fell(INT_N));
  c_power_off: cover property ($fell(POWER_ENABLE));
endmodule : pbseq_checker
bind pushbutton_power_sequencer pbseq_checker #(
  .RESET_PULSE_CYC(RESET_PULSE_CYC),
  .INT_MIN_CYC(INT_MIN_CYC)
) chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PINS(PINS), .POWER_ENABLE(POWER_ENABLE),
  .INT_N(INT_N), .RESET_N(RESET_N), .REF_ENABLE(REF_ENABLE),
  .HOLD_PULLDOWN_EN(HOLD_PULLDOWN_EN));
`default_nettype wire

/* File: pbseq_host_model.sv */
// Purpose: Host processor model on the hold-confirm pin
// Assumes: Host runs only while powered and out of reset
// Notes:   A floating pin toggles so it never reads as a steady level
`timescale 1ns/1ps
`default_nettype none
module pbseq_host_model
(
  input  wire logic SYS_CLK,
  input  wire logic RST_N,
  input  wire logic POWER_ON,
  input  wire logic DEV_RESET_N,
  input  wire logic PULLDOWN_EN,
  input  wire logic CONFIRM,
  output var  logic HOLD
);
  logic drive_reg;
  logic float_reg;
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      drive_reg <= 1'b0;
      float_reg <= 1'b0;
    end
    else
    begin
      drive_reg <= POWER_ON & DEV_RESET_N;
      float_reg <= ~float_reg;
    end
  end
  assign HOLD = drive_reg ? CONFIRM : (PULLDOWN_EN ? 1'b0 : float_reg);
endmodule : pbseq_host_model
`default_nettype wire

/* File: pbseq_tb.sv */
// Purpose: Self-checking bench for the power sequencer
// Assumes: Host model answers on hold-confirm
// Notes:   Short timing parameters keep the run brief
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pbseq_pkg::*;
  localparam int DEB = 20;
  localparam int IMIN = 10;
  localparam int RP = 15;
  localparam int BLK = 50;
  logic      sys_clk;
  logic      rst_n;
  logic      pb_n;
  logic      sb_n;
  logic      low;
  logic      cap;
  logic      confirm;
  wire logic hold;
  pins_in_t  pins;
  logic      pe;
  logic      int_n;
  logic      res_n;
  logic      slo_n;
  logic      bout_n;
  logic      ref_en;
  logic      pd_en;
  int        num_errors;
  int        tests_run;
  int        len;
  assign pins = {pb_n, sb_n, hold, low, cap};
  pushbutton_power_sequencer #(.DEBOUNCE_CYC(DEB), .INT_MIN_CYC(IMIN), .RESET_PULSE_CYC(RP),
    .ON_BLANK_CYC(BLK)) DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .PINS(pins),
    .POWER_ENABLE(pe), .INT_N(int_n), .RESET_N(res_n), .BUTTON_STATE_OUT_N(bout_n),
    .SUPPLY_LOW_N(slo_n), .REF_ENABLE(ref_en), .HOLD_PULLDOWN_EN(pd_en));
  pbseq_host_model host (.SYS_CLK(sys_clk), .RST_N(rst_n), .POWER_ON(pe),
    .DEV_RESET_N(res_n), .PULLDOWN_EN(pd_en), .CONFIRM(confirm), .HOLD(hold));
  task automatic check(input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks=%0d errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  function automatic logic outv(input int w);
    return w == 0 ? pe : w == 1 ? int_n : w == 2 ? res_n : pd_en;
  endfunction : outv
  function automatic logic pe_after(input int n);
    return n >= DEB ? 1'b1 : 1'b0;
  endfunction : pe_after
  // Bounded wait; running out is a mismatch and ends the run
  task automatic wait_for(input int w, input logic v, input int n);
    while (outv(w) !== v && n > 0)
    begin
      cyc(1);
      n--;
    end
    check(outv(w), v);
    if (outv(w) !== v)
      end_sim();
  endtask : wait_for
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    num_errors = 0;
    tests_run = 0;
    {rst_n, low, cap} = 3'h0;
    {pb_n, sb_n, confirm} = 3'h7;
    len = $urandom(32'h118F5930);
    cyc(3);
    rst_n = 1'b1;
    cyc(4);
    repeat (3)
    begin
      len = $urandom_range(DEB - 6, 1);
      pb_n = 1'b0;
      cyc(len);
      pb_n = 1'b1;
      cyc(10 + $urandom_range(5, 0));
      check(pe, pe_after(len));
    end
    $display("test short_press done");
    pb_n = 1'b0;
    cyc(10);
    low = 1'b1;
    cyc(5);
    low = 1'b0;
    cyc(DEB - 4);
    check(pe, 1'b0);
    wait_for(0, 1'b1, 15);
    // Reset falls one edge after enable rises
    cyc(1);
    check(res_n, 1'b0);
    check(pd_en, 1'b1);
    wait_for(2, 1'b1, RP + 4);
    cyc(1);
    check(ref_en, 1'b1);
    cyc(8);
    pb_n = 1'b1;
    wait_for(3, 1'b0, BLK);
    check(pe, 1'b1);
    $display("test power_on done");
    pb_n = 1'b0;
    wait_for(1, 1'b0, DEB + 8);
    check(bout_n, 1'b0);
    cyc(2);
    pb_n = 1'b1;
    cyc(IMIN - 6);
    check(int_n, 1'b0);
    wait_for(1, 1'b1, IMIN + 8);
    check(bout_n, 1'b1);
    low = 1'b1;
    wait_for(1, 1'b0, 8);
    cyc(1);
    check(slo_n, 1'b0);
    low = 1'b0;
    wait_for(1, 1'b1, IMIN + 8);
    $display("test interrupt done");
    pb_n = 1'b0;
    cyc(4);
    sb_n = 1'b0;
    cyc(DEB + IMIN + 8);
    check(res_n, 1'b1);
    cap = 1'b1;
    wait_for(2, 1'b0, 8);
    wait_for(2, 1'b1, RP + 4);
    cyc(8);
    {pb_n, sb_n, cap} = 3'h6;
    wait_for(3, 1'b0, BLK);
    check(pe, 1'b1);
    $display("test long_push done");
    confirm = 1'b0;
    wait_for(0, 1'b0, 10);
    cyc(2);
    check(ref_en, 1'b0);
    pb_n = 1'b0;
    wait_for(0, 1'b1, DEB + 8);
    cyc(BLK - 6);
    check(pe, 1'b1);
    wait_for(0, 1'b0, 12);
    pb_n = 1'b1;
    cyc(6);
    pb_n = 1'b0;
    wait_for(0, 1'b1, DEB + 8);
    cyc(RP + 4);
    pb_n = 1'b1;
    wait_for(0, 1'b0, 8);
    $display("test failed_start done");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
